// >>> rtl/itc_pkg.sv
// constants, types and decode functions for the i2c target command front end
package itc_pkg;

	localparam logic [4:0] TGT_ADDR_HI   = 5'h0b;
	localparam logic [7:0] GC_ADDR       = 8'h00;
	localparam logic [4:0] HS_CODE_HI    = 5'h01;
	localparam logic [1:0] OPF_WR_HI     = 2'h0;
	localparam logic [1:0] OPF_RD_HI     = 2'h3;
	localparam logic [2:0] OPF_WR_GC     = 3'h0;
	localparam logic [2:0] OPF_INC       = 3'h2;
	localparam logic [2:0] OPF_DEC       = 3'h4;
	localparam logic [3:0] BIT_ACK       = 4'h8;
	localparam logic [3:0] BIT_POST_ACK  = 4'h9;
	localparam logic [4:0] RA_VOL_W0     = 5'h01;
	localparam logic [4:0] RA_VOL_W1     = 5'h02;
	localparam logic [4:0] RA_NV_W0      = 5'h03;
	localparam logic [4:0] RA_GP_DATA2   = 5'h07;
	localparam logic [4:0] RA_LOCK       = 5'h09;
	localparam logic [4:0] RA_CRC        = 5'h0c;
	localparam logic [4:0] RA_RESET      = 5'h0d;
	localparam logic [4:0] RA_CNT_FIRST  = 5'h15;
	localparam logic [4:0] RA_CNT_LAST   = 5'h1d;

	typedef enum logic [1:0] {OP_WRITE, OP_INC, OP_DEC} itc_op_t;

	typedef enum logic [2:0] {
		PH_IDLE, PH_CTRL, PH_CMD, PH_DHI, PH_DLO, PH_CHK, PH_IGNORE
	} itc_phase_t;

	typedef struct packed {
		logic [4:0] addr;
		itc_op_t    op;
		logic       nv;
		logic [9:0] data;
	} itc_word_t;

	function automatic logic wr_ok(input logic [4:0] a);
		return (a >= RA_VOL_W0 && a <= RA_GP_DATA2) || (a >= RA_LOCK && a <= RA_RESET);
	endfunction

	function automatic logic rd_ok(input logic [4:0] a);
		return (a >= RA_VOL_W0 && a <= RA_CRC) ||
			(a >= RA_CNT_FIRST && a <= RA_CNT_LAST && a[0]);
	endfunction

	function automatic logic is_wiper(input logic [4:0] a);
		return a == RA_VOL_W0 || a == RA_VOL_W1;
	endfunction

	function automatic logic is_nv(input logic [4:0] a);
		return a >= RA_NV_W0 && a <= RA_GP_DATA2;
	endfunction

	function automatic logic gc_ok(input logic [7:0] c);
		return (c[2:0] == OPF_WR_GC && wr_ok(c[7:3])) ||
			((c[2:0] == OPF_INC || c[2:0] == OPF_DEC) && is_wiper(c[7:3]));
	endfunction

endpackage

// >>> rtl/itc_target.sv
// i2c target command front end: link engine on link_clk, register side on ref_clk
// Function
// [RULE_01] nack speed code byte, enter high speed
// [RULE_02] leave high speed at next stop
// [RULE_03] controller restarts after nacked speed code
// [RULE_04] speed code byte carries no checksum byte
// [RULE_05] ack general call address, then command
// [RULE_06] general call accepts listed write commands
// [RULE_07] general call accepts wiper increment, decrement
// [RULE_08] nack unsupported general call command bytes
// [RULE_09] one command per general call address
// [RULE_10] command byte splits address and operation
// [RULE_11] decode write, read, increment, decrement
// [RULE_12] write and read take two data bytes
// [RULE_13] nack invalid address and operation pairs
// [RULE_14] after error ignore bytes until start/stop
// [RULE_15] corruption releases bus until new start
// [RULE_16] early termination abandons the command
// [RULE_17] ten bit value right aligned, padding dropped
// [RULE_18] commit at ack rising edge only
// [RULE_19] continuous write groups commit each at ack
// [RULE_20] controller keeps continuous writes volatile only
// [RULE_21] no continuous write with checksum enabled
// [RULE_22] checksum byte extends every command format
// [RULE_23] address is 01011 plus two select pins
// [RULE_24] never stretch the clock
// [RULE_25] nack increment at full scale, decrement at zero
module itc_target
	import itc_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             link_clk,
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe,
	input  wire logic             addr_select_pin_low,
	input  wire logic             addr_select_pin_high,
	input  wire logic             checksum_enable_bit,
	input  wire logic [1:0]       wiper_at_max,
	input  wire logic [1:0]       wiper_at_min,
	output itc_pkg::itc_word_t    wr_word,
	output logic                  wr_stb,
	output logic                  hs_mode
);
	import itc_pkg::*;

	typedef struct packed {
		logic [1:0]      rst_s;
		logic [1:0]      en_s;
		logic [1:0]      scl_s;
		logic [1:0]      sda_s;
		logic [1:0]      chk_s;
		logic [1:0][1:0] max_s;
		logic [1:0][1:0] min_s;
		logic [1:0][1:0] apin_s;
		logic            scl_p;
		logic            sda_p;
		logic [1:0]      own_lo;
		itc_phase_t      phase;
		logic [3:0]      cnt;
		logic [7:0]      shreg;
		logic            gc;
		logic            gc_used;
		logic            hs;
		logic            oe;
		logic            sda_o;
		logic            pend;
		itc_word_t       cur;
		itc_word_t       out;
		logic            tgl;
	} itc_link_t;

	typedef struct packed {
		logic [2:0] tgl_s;
		logic [1:0] hs_s;
		itc_word_t  word;
		logic       stb;
		logic       hs;
	} itc_ref_t;

	itc_link_t l_q;
	itc_link_t l_d;
	itc_ref_t  r_q;
	itc_ref_t  r_d;

	logic       run;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic       byte_done;
	logic       ack_rise;
	logic [4:0] c_addr;
	logic [2:0] c_op;
	logic       c_wr;
	logic       c_rd;
	logic       c_inc;
	logic       c_dec;
	logic       c_idx;
	logic       c_valid;
	logic       c_sat;
	logic       c_accept;
	logic       chk_on;

	// edge and condition detection on the synchronised pins only
	assign run       = l_q.rst_s[1] & l_q.en_s[1];
	assign scl_rise  = run & l_q.scl_s[1] & ~l_q.scl_p;
	assign scl_fall  = run & ~l_q.scl_s[1] & l_q.scl_p;
	assign bus_start = run & l_q.scl_s[1] & l_q.scl_p & l_q.sda_p & ~l_q.sda_s[1];
	assign bus_stop  = run & l_q.scl_s[1] & l_q.scl_p & ~l_q.sda_p & l_q.sda_s[1];
	assign byte_done = scl_fall & (l_q.cnt == BIT_ACK) & (l_q.phase != PH_IDLE);
	assign ack_rise  = scl_rise & (l_q.cnt == BIT_ACK) & (l_q.phase != PH_IDLE);
	assign chk_on    = l_q.chk_s[1];

	// command byte fields and validity
	assign c_addr   = l_q.shreg[7:3]; // RULE_10
	assign c_op     = l_q.shreg[2:0]; // RULE_10
	assign c_wr     = c_op[2:1] == OPF_WR_HI; // RULE_11
	assign c_rd     = c_op[2:1] == OPF_RD_HI; // RULE_11
	assign c_inc    = c_op == OPF_INC; // RULE_11
	assign c_dec    = c_op == OPF_DEC; // RULE_11
	assign c_idx    = c_addr == RA_VOL_W1;
	assign c_valid  = l_q.gc ? gc_ok(l_q.shreg) : // RULE_06 RULE_07 RULE_08
		((c_wr & wr_ok(c_addr)) | (c_rd & rd_ok(c_addr)) |
		((c_inc | c_dec) & is_wiper(c_addr))); // RULE_13
	assign c_sat    = (c_inc & l_q.max_s[1][c_idx]) | (c_dec & l_q.min_s[1][c_idx]); // RULE_25
	assign c_accept = c_valid & ~c_sat & ~l_q.gc_used; // RULE_09

	always_comb begin
		l_d        = l_q;
		l_d.rst_s  = {l_q.rst_s[0], reset_n};
		l_d.en_s   = {l_q.en_s[0], clk_en};
		l_d.scl_s  = {l_q.scl_s[0], scl_in};
		l_d.sda_s  = {l_q.sda_s[0], sda_in};
		l_d.chk_s  = {l_q.chk_s[0], checksum_enable_bit};
		l_d.max_s  = {l_q.max_s[0], wiper_at_max};
		l_d.min_s  = {l_q.min_s[0], wiper_at_min};
		l_d.apin_s = {l_q.apin_s[0], {addr_select_pin_high, addr_select_pin_low}};
		if (!l_q.rst_s[1]) begin
			// straps are held static, so catching them during reset is safe
			l_d.own_lo  = l_q.apin_s[1]; // RULE_23
			l_d.scl_p   = 1'b1;
			l_d.sda_p   = 1'b1;
			l_d.phase   = PH_IDLE;
			l_d.cnt     = 4'h0;
			l_d.shreg   = 8'h00;
			l_d.gc      = 1'b0;
			l_d.gc_used = 1'b0;
			l_d.hs      = 1'b0;
			l_d.oe      = 1'b0;
			l_d.sda_o   = 1'b0;
			l_d.pend    = 1'b0;
			l_d.cur     = '0;
			l_d.out     = '0;
			l_d.tgl     = 1'b0;
		end else if (l_q.en_s[1]) begin
			l_d.scl_p = l_q.scl_s[1];
			l_d.sda_p = l_q.sda_s[1];
			if (bus_start) begin
				// a pending group dies here: nothing commits without its ack
				l_d.phase   = PH_CTRL; // RULE_14 RULE_15
				l_d.cnt     = 4'h0;
				l_d.oe      = 1'b0;
				l_d.pend    = 1'b0; // RULE_16 RULE_18
				l_d.gc      = 1'b0;
				l_d.gc_used = 1'b0;
			end else if (bus_stop) begin
				l_d.phase = PH_IDLE; // RULE_14
				l_d.hs    = 1'b0; // RULE_02
				l_d.oe    = 1'b0;
				l_d.pend  = 1'b0; // RULE_16 RULE_18
			end else if (l_q.phase != PH_IDLE) begin
				if (scl_rise) begin
					if (l_q.cnt < BIT_ACK) begin
						l_d.shreg = {l_q.shreg[6:0], l_q.sda_s[1]};
						l_d.cnt   = l_q.cnt + 4'h1;
					end else if (l_q.cnt == BIT_ACK) begin
						l_d.cnt = BIT_POST_ACK;
						if (l_q.oe && l_q.sda_s[1]) begin
							// our ack did not reach the wire: drop off the bus
							l_d.oe    = 1'b0; // RULE_15
							l_d.pend  = 1'b0;
							l_d.phase = PH_IGNORE; // RULE_15
						end else if (l_q.pend) begin
							l_d.out  = l_q.cur; // RULE_18 RULE_19
							l_d.tgl  = ~l_q.tgl; // RULE_18
							l_d.pend = 1'b0;
						end
					end
				end else if (scl_fall) begin
					if (l_q.cnt == BIT_POST_ACK) begin
						l_d.oe  = 1'b0;
						l_d.cnt = 4'h0;
					end else if (l_q.cnt == BIT_ACK) begin
						unique case (l_q.phase)
							PH_CTRL: begin
								if (l_q.shreg[7:3] == HS_CODE_HI) begin
									// no ack; controller restarts, no checksum byte follows
									l_d.hs    = 1'b1; // RULE_01 RULE_03 RULE_04
									l_d.oe    = 1'b0; // RULE_01
									l_d.phase = PH_IGNORE;
								end else if (l_q.shreg == GC_ADDR) begin
									l_d.gc    = 1'b1;
									l_d.oe    = 1'b1; // RULE_05
									l_d.phase = PH_CMD; // RULE_05
								end else if (l_q.shreg[7:1] == {TGT_ADDR_HI, l_q.own_lo}) begin
									// read data is served elsewhere; only writes continue here
									l_d.oe    = 1'b1; // RULE_23
									l_d.phase = l_q.shreg[0] ? PH_IGNORE : PH_CMD;
								end else begin
									l_d.oe    = 1'b0;
									l_d.phase = PH_IGNORE;
								end
							end
							PH_CMD: begin
								if (c_accept) begin
									l_d.oe       = 1'b1;
									l_d.cur.addr = c_addr; // RULE_10
									l_d.cur.nv   = is_nv(c_addr);
									l_d.cur.data = 10'h000;
									l_d.cur.op   = c_wr ? OP_WRITE : (c_inc ? OP_INC : OP_DEC);
									l_d.gc_used  = l_q.gc; // RULE_09
									if (c_rd) begin
										l_d.phase = PH_IGNORE;
									end else if (c_wr) begin
										l_d.phase = PH_DHI; // RULE_12
									end else if (chk_on) begin
										l_d.phase = PH_CHK; // RULE_12 RULE_22
									end else begin
										l_d.pend  = 1'b1; // RULE_12
										l_d.phase = PH_CMD;
									end
								end else begin
									l_d.oe    = 1'b0; // RULE_08 RULE_13 RULE_25
									l_d.phase = PH_IGNORE; // RULE_14
								end
							end
							PH_DHI: begin
								l_d.cur.data[9:8] = l_q.shreg[1:0]; // RULE_17
								l_d.oe            = 1'b1;
								l_d.phase         = PH_DLO;
							end
							PH_DLO: begin
								l_d.cur.data[7:0] = l_q.shreg; // RULE_17
								l_d.oe            = 1'b1;
								if (chk_on) begin
									l_d.phase = PH_CHK; // RULE_22
								end else begin
									// next byte is a fresh command of the same write
									l_d.pend  = 1'b1; // RULE_18 RULE_19 RULE_20
									l_d.phase = PH_CMD; // RULE_19
								end
							end
							PH_CHK: begin
								// checksum value itself is never checked or passed on; any byte is acked
								l_d.oe    = 1'b1;
								l_d.pend  = 1'b1; // RULE_22
								l_d.phase = PH_IGNORE; // RULE_21
							end
							PH_IGNORE: begin
								l_d.oe = 1'b0; // RULE_14
							end
							PH_IDLE: begin
								l_d.oe = 1'b0;
							end
						endcase
					end
				end
			end
		end
	end

	always_ff @(posedge link_clk) begin
		l_q <= l_d;
	end

	// register side: toggle crossing, word is stable long before the toggle lands
	always_comb begin
		r_d = r_q;
		if (!reset_n) begin
			r_d.tgl_s = 3'h0;
			r_d.hs_s  = 2'h0;
			r_d.word  = '0;
			r_d.stb   = 1'b0;
			r_d.hs    = 1'b0;
		end else if (clk_en) begin
			r_d.tgl_s = {r_q.tgl_s[1:0], l_q.tgl};
			r_d.hs_s  = {r_q.hs_s[0], l_q.hs};
			r_d.hs    = r_q.hs_s[1];
			r_d.stb   = r_q.tgl_s[2] ^ r_q.tgl_s[1]; // RULE_18
			if (r_q.tgl_s[2] ^ r_q.tgl_s[1]) begin
				r_d.word = l_q.out;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		r_q <= r_d;
	end

	// scl is never driven, so the clock cannot be stretched
	assign sda_out = l_q.sda_o; // RULE_24
	assign sda_oe  = l_q.oe;
	assign wr_word = r_q.word;
	assign wr_stb  = r_q.stb;
	assign hs_mode = r_q.hs;

	hs_entry_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_01
		byte_done && l_q.phase == PH_CTRL && l_q.shreg[7:3] == HS_CODE_HI
		|=> l_q.hs && !l_q.oe ##1 l_q.phase == PH_IGNORE || bus_start || bus_stop)
		else $error("speed code byte not nacked or mode not entered");

	hs_exit_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_02
		bus_stop |=> !l_q.hs && l_q.phase == PH_IDLE)
		else $error("high speed mode survived a stop");

	gc_ack_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_05
		byte_done && l_q.phase == PH_CTRL && l_q.shreg == GC_ADDR
		|=> l_q.oe && l_q.gc && l_q.phase == PH_CMD)
		else $error("general call address not acknowledged");

	gc_once_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_09
		byte_done && l_q.phase == PH_CMD && l_q.gc_used |=> !l_q.oe)
		else $error("second general call command acknowledged");

	bad_cmd_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_13
		byte_done && l_q.phase == PH_CMD && !c_valid
		|=> !l_q.oe && l_q.phase == PH_IGNORE)
		else $error("invalid command acknowledged");

	ignore_hold_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_14
		l_q.phase == PH_IGNORE && !l_q.pend && !bus_start && !bus_stop
		|=> l_q.phase == PH_IGNORE && !l_q.pend && !$changed(l_q.tgl))
		else $error("ignored bytes changed the command state");

	no_stretch_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_24
		$rose(l_q.oe) |-> !l_q.scl_p && !l_q.sda_o)
		else $error("data driven outside the low clock phase");

	commit_edge_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_18
		$changed(l_q.tgl) |-> $past(ack_rise) && $past(l_q.pend) && !$past(l_q.sda_s[1]))
		else $error("commit away from the acknowledge rising edge");

	abort_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_16
		bus_start || bus_stop |=> !l_q.pend && !l_q.oe ##1 !$changed(l_q.tgl))
		else $error("terminated command still committed");

	sat_nack_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_25
		byte_done && l_q.phase == PH_CMD && c_inc && l_q.max_s[1][c_idx] |=> !l_q.oe)
		else $error("increment at full scale acknowledged");

	hi_bits_a: assert property (@(posedge link_clk) disable iff (!l_q.rst_s[1]) // RULE_17
		byte_done && l_q.phase == PH_DHI |=> l_q.cur.data[9:8] == $past(l_q.shreg[1:0]))
		else $error("upper data bits not right aligned");

	stb_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_18
		clk_en && r_q.stb |=> !r_q.stb)
		else $error("write strobe longer than one cycle");

	hs_seen_c: cover property (@(posedge link_clk) disable iff (!l_q.rst_s[1])
		$rose(l_q.hs));

	gc_commit_c: cover property (@(posedge link_clk) disable iff (!l_q.rst_s[1])
		l_q.gc && $changed(l_q.tgl));

	cont_write_c: cover property (@(posedge link_clk) disable iff (!l_q.rst_s[1])
		$changed(l_q.tgl) ##[1:1000] l_q.phase == PH_CMD && $changed(l_q.tgl));

endmodule // itc_target

// >>> tb/itc_ctrl_model.sv
// i2c bus controller model: drives scl and pulls sda low on falling ref_clk edges
module itc_ctrl_model (
	input  wire logic ref_clk,
	input  wire logic sda_bus,
	output logic      scl,
	output logic      sda_low
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// quarter bit of 2 ref clocks, slow enough for the target's input sync
	task automatic ph(input logic c, input logic d_low);
		scl = c;
		sda_low = d_low;
		repeat (2) @(negedge ref_clk);
	endtask

	// sda only moves while scl is low, except for start and stop
	task automatic start();
		ph(1'b0, 1'b0);
		ph(1'b1, 1'b0);
		ph(1'b1, 1'b1);
		ph(1'b0, 1'b1);
	endtask

	task automatic stop();
		ph(1'b0, 1'b1);
		ph(1'b1, 1'b1);
		ph(1'b1, 1'b0);
	endtask

	task automatic bit_io(input logic b, output logic s);
		ph(1'b0, ~b);
		ph(1'b1, ~b);
		s = sda_bus;
		ph(1'b1, ~b);
		ph(1'b0, ~b);
	endtask

	// ack bit released so the pull-up shows a refusal
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
endmodule // itc_ctrl_model

// >>> tb/itc_target_tb.sv
// self-checking bench for the i2c target command front end
module itc_target_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import itc_pkg::*;

	logic       ref_clk;
	logic       link_clk;
	logic       reset_n;
	logic       csum;
	logic       scl;
	logic       sda_low;
	logic       sda_hi;
	logic       sda_out;
	logic       sda_oe;
	logic       wr_stb;
	logic       hs_mode;
	logic [1:0] at_max;
	logic [1:0] at_min;
	itc_word_t  wr_word;
	itc_word_t  got_q[$];
	int         mismatches;
	int         samples_checked;
	wire logic  sda;

	// pull-up: wire is low while any party pulls it; sda_hi models a corrupting driver
	assign sda = sda_hi | ~(sda_low | (sda_oe & ~sda_out));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	itc_target dut (
		.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1), .link_clk(link_clk),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_select_pin_low(1'b0), .addr_select_pin_high(1'b1),
		.checksum_enable_bit(csum), .wiper_at_max(at_max), .wiper_at_min(at_min),
		.wr_word(wr_word), .wr_stb(wr_stb), .hs_mode(hs_mode));

	itc_ctrl_model bus (.ref_clk(ref_clk), .sda_bus(sda), .scl(scl), .sda_low(sda_low));

	// sampled mid-cycle, away from the edge that launches the strobe
	always @(negedge ref_clk) begin
		if (wr_stb === 1'b1) begin
			got_q.push_back(wr_word);
		end
	end

	task automatic end_sim();
		$display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wb(input logic [7:0] b, input logic ea);
		logic a;
		bus.wr_byte(b, a);
		chk({31'h0, a}, {31'h0, ea});
	endtask

	// strobe arrives a few ref clocks after the ack rise
	task automatic take(output itc_word_t w);
		for (int n = 0; n < 40 && got_q.size() == 0; n++) @(negedge ref_clk);
		if (got_q.size() == 0) begin
			chk(32'h0, 32'h1);
			end_sim();
		end else begin
			w = got_q.pop_front();
		end
	endtask

	task automatic wchk(input logic [4:0] a, input logic nv, input logic [9:0] d);
		itc_word_t w;
		take(w);
		chk(32'(w), {14'h0, a, OP_WRITE, nv, d});
	endtask

	task automatic none_chk();
		repeat (20) @(negedge ref_clk);
		chk(32'(got_q.size()), 32'h0);
	endtask

	task automatic hs_chk(input logic v);
		for (int n = 0; n < 40 && hs_mode !== v; n++) @(negedge ref_clk);
		chk({31'h0, hs_mode}, {31'h0, v});
	endtask

	task automatic s_write();
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h08, 1'b1);
		wb(8'hfe, 1'b1);
		wb(8'h5a, 1'b1);
		bus.stop();
		wchk(RA_VOL_W0, 1'b0, 10'h25a);
		bus.start();
		wb(8'h5e, 1'b0);
		bus.stop();
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h18, 1'b1);
		wb(8'h03, 1'b1);
		wb(8'hff, 1'b1);
		bus.stop();
		wchk(RA_NV_W0, 1'b1, 10'h3ff);
	endtask

	// volatile only, ended by stop
	task automatic s_cont();
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h09, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h11, 1'b1);
		wchk(RA_VOL_W0, 1'b0, 10'h011);
		wb(8'h10, 1'b1);
		wb(8'h01, 1'b1);
		wb(8'h22, 1'b1);
		bus.stop();
		wchk(RA_VOL_W1, 1'b0, 10'h122);
	endtask

	task automatic s_abort();
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h08, 1'b1);
		wb(8'h01, 1'b1);
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h10, 1'b1);
		bus.stop();
		none_chk();
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h6e, 1'b0);
		wb(8'h08, 1'b0);
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'ha8, 1'b0);
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h0e, 1'b1);
		bus.stop();
		none_chk();
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h08, 1'b1);
		sda_hi = 1'b1;
		wb(8'hff, 1'b0);
		sda_hi = 1'b0;
		wb(8'h5a, 1'b0);
		bus.stop();
		none_chk();
	endtask

	task automatic s_gc();
		logic [7:0] cmd [4] = '{8'h0a, 8'h12, 8'h0c, 8'h14};
		logic       ea  [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
		itc_word_t  w;
		for (logic [4:0] a = 5'h01; a <= 5'h0d; a++) begin
			if (a != 5'h08) begin
				bus.start();
				wb(8'h00, 1'b1);
				wb({a, 3'b000}, 1'b1);
				wb(8'h02, 1'b1);
				wb({3'h0, a}, 1'b1);
				bus.stop();
				wchk(a, a >= 5'h03 && a <= 5'h07, {5'h10, a});
			end
		end
		for (int i = 0; i < 4; i++) begin
			bus.start();
			wb(8'h00, 1'b1);
			wb(cmd[i], ea[i]);
			if (ea[i]) begin
				take(w);
				chk({24'h0, w.addr, 3'(w.op)},
					{24'h0, cmd[i][7:3], ((i < 2) ? 3'(OP_INC) : 3'(OP_DEC))});
				wb(8'h0a, 1'b0);
			end
			bus.stop();
		end
		bus.start();
		wb(8'h00, 1'b1);
		wb(8'h40, 1'b0);
		bus.stop();
		none_chk();
	endtask

	// speed code nacked, then restart as the controller must
	task automatic s_hs();
		bus.start();
		wb(8'h0b, 1'b0);
		hs_chk(1'b1);
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h10, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h07, 1'b1);
		wchk(RA_VOL_W1, 1'b0, 10'h007);
		chk({31'h0, hs_mode}, 32'h1);
		bus.stop();
		hs_chk(1'b0);
	endtask

	task automatic s_csum();
		csum = 1'b1;
		bus.start();
		wb(8'h5c, 1'b1);
		wb(8'h08, 1'b1);
		wb(8'h01, 1'b1);
		wb(8'h44, 1'b1);
		none_chk();
		wb(8'ha5, 1'b1);
		wchk(RA_VOL_W0, 1'b0, 10'h144);
		wb(8'h08, 1'b0);
		bus.stop();
		csum = 1'b0;
	endtask

	initial begin
		repeat (90000) @(posedge ref_clk);
		chk(32'h0, 32'h1);
		end_sim();
	end

	initial begin
		mismatches = 0;
		samples_checked = 0;
		reset_n = 1'b0;
		csum = 1'b0;
		sda_hi = 1'b0;
		at_max = 2'b10;
		at_min = 2'b01;
		repeat (12) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		s_write();
		s_cont();
		s_abort();
		s_gc();
		s_hs();
		s_csum();
		end_sim();
	end
endmodule // itc_target_tb
